// [logic/adcrrb_consts.vh]
// Purpose: constants of the ADC request/result bank
// Assumes: 20-bit register payload, 7-bit register identifiers
// Notes: included by both design files
`ifndef ADCRRB_CONSTS_VH
`define ADCRRB_CONSTS_VH

// ==========================================
// Register identifiers
`define ADCRRB_ID_CHAN_A 7'h3A
`define ADCRRB_ID_CHAN_B 7'h3B
`define ADCRRB_ID_CHAN_C 7'h3C
`define ADCRRB_ID_CHAN_D 7'h3D

// ==========================================
// Field layout of a channel register
`define ADCRRB_DATA_W 20
`define ADCRRB_SEL_W 7
`define ADCRRB_RES_W 10
`define ADCRRB_FLAG_BIT 19
`define ADCRRB_ECHO_MSB 16
`define ADCRRB_ECHO_LSB 10
`define ADCRRB_RES_MSB 9
`define ADCRRB_RES_LSB 0

// ==========================================
// Reset values
`define ADCRRB_SEL_RST 7'h00
`define ADCRRB_RES_RST 10'h000
`define ADCRRB_FLAG_RST 1'b0

// ==========================================
// Selector codes
`define ADCRRB_SEL_UNUSED 7'h00
`define ADCRRB_SEL_GND_REF 7'h01
`define ADCRRB_SEL_FULL_REF 7'h02
`define ADCRRB_SEL_DCS_VOLT 7'h03
`define ADCRRB_SEL_DCS_CURR 7'h04
`define ADCRRB_SEL_DCS_RES 7'h05
`define ADCRRB_SEL_SQUIB_RES 7'h06
`define ADCRRB_SEL_BG_REF 7'h07
`define ADCRRB_SEL_BG_MON 7'h08
`define ADCRRB_SEL_VCORE 7'h09
`define ADCRRB_SEL_TEMP 7'h0A
`define ADCRRB_SEL_DCS0 7'h0B
`define ADCRRB_SEL_DCS8 7'h13
`define ADCRRB_SEL_ESR_VB 7'h14
`define ADCRRB_SEL_ESR_VA 7'h15
`define ADCRRB_SEL_ESR_VC 7'h16
`define ADCRRB_SEL_SUPPLY_LO 7'h20
`define ADCRRB_SEL_SUPPLY_HI 7'h2B
`define ADCRRB_SEL_GPO_LO 7'h2C
`define ADCRRB_SEL_GPO_HI 7'h31
`define ADCRRB_SEL_RSU_LO 7'h32
`define ADCRRB_SEL_RSU_HI 7'h35
`define ADCRRB_SEL_SS_LO 7'h36
`define ADCRRB_SEL_SS_HI 7'h41
`define ADCRRB_SEL_SF_LO 7'h46
`define ADCRRB_SEL_SF_HI 7'h4D

`endif

// [logic/adcrrb_channel.v]
// Purpose: one request/result channel of the ADC bank
// Assumes: single clock, write/read strobes one cycle wide
// Notes: holds selector, result and conversion_done_flag
`timescale 1ns/100ps
`include "adcrrb_consts.vh"

module adcrrb_channel (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_state_reset,
  input wire i_write,
  input wire i_read,
  input wire [`ADCRRB_DATA_W-1:0] i_wdata,
  input wire i_conv_done,
  input wire [`ADCRRB_RES_W-1:0] i_conv_result,
  input wire [`ADCRRB_SEL_W-1:0] i_conv_label,
  input wire i_label_valid,
  output reg [`ADCRRB_SEL_W-1:0] o_measurement_selector,
  output reg [`ADCRRB_SEL_W-1:0] o_echo_selector,
  output reg [`ADCRRB_RES_W-1:0] o_conversion_result,
  output reg o_conversion_done_flag,
  output wire o_conv_request
);

  // ==========================================
  // Code validity: only listed codes request a conversion
  reg sel_valid;
  always @* begin
    sel_valid = 1'b0;
    if ((o_measurement_selector >= `ADCRRB_SEL_GND_REF) &&
        (o_measurement_selector <= `ADCRRB_SEL_ESR_VC)) begin // RQ5 RQ6 RQ7
      sel_valid = 1'b1;
    end
    if ((o_measurement_selector >= `ADCRRB_SEL_SUPPLY_LO) &&
        (o_measurement_selector <= `ADCRRB_SEL_SS_HI)) begin // RQ8 RQ9
      sel_valid = 1'b1;
    end
    if ((o_measurement_selector >= `ADCRRB_SEL_SF_LO) &&
        (o_measurement_selector <= `ADCRRB_SEL_SF_HI)) begin // RQ9
      sel_valid = 1'b1;
    end
  end

  assign o_conv_request = sel_valid; // RQ10

  // ==========================================
  // Channel registers
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_measurement_selector <= `ADCRRB_SEL_RST; // RQ4
      o_echo_selector <= `ADCRRB_SEL_RST;
      o_conversion_result <= `ADCRRB_RES_RST;
      o_conversion_done_flag <= `ADCRRB_FLAG_RST;
    end else if (i_state_reset) begin
      o_measurement_selector <= `ADCRRB_SEL_RST; // RQ4
      o_echo_selector <= `ADCRRB_SEL_RST;
      o_conversion_result <= `ADCRRB_RES_RST;
      o_conversion_done_flag <= `ADCRRB_FLAG_RST;
    end else begin
      if (i_write) begin
        o_measurement_selector <= i_wdata[`ADCRRB_SEL_W-1:0]; // RQ1
        o_echo_selector <= i_wdata[`ADCRRB_SEL_W-1:0];
      end else if (i_conv_done && i_label_valid) begin
        o_echo_selector <= i_conv_label; // RQ7
      end
      if (i_conv_done && sel_valid) begin
        o_conversion_result <= i_conv_result; // RQ11
        o_conversion_done_flag <= 1'b1; // RQ3
      end else if (i_read) begin
        o_conversion_done_flag <= 1'b0; // RQ3 RQ11
      end
    end
  end

endmodule // adcrrb_channel

// [logic/adcrrb_bank.v]
// Purpose: four-channel ADC request/result register bank
// Assumes: SPI frame decoder on the same clock gives id, data and strobes
// Notes: conversion engine is outside; it reports per-channel completion
//
// Summary of operation
// RQ1 - Four channels; write keeps selector bits 6:0
// RQ2 - Read: flag, zeros, selector echo, result
// RQ3 - Flag set at conversion end, cleared by read
// RQ4 - All fields zero on every reset kind
// RQ5 - Codes 03-06, 0B-13 select sensor and squib measurements
// RQ6 - Codes 01-02, 07-0A select references, core, temperature
// RQ7 - Codes 14-16 only echoed for SERIES_RESISTANCE_MEASURE results
// RQ8 - Codes 20-2B select supply and pin voltages
// RQ9 - Codes 2C-41, 46-4D select output/sensor/squib pins
// RQ10 - Unlisted codes request nothing, flag untouched
// RQ11 - Read clears own flag; result held
`timescale 1ns/100ps
`include "adcrrb_consts.vh"

module adcrrb_bank #(
  parameter CHANNELS = 4
) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_wake_pin_state_reset,
  input wire i_system_state_reset,
  input wire i_reg_write,
  input wire i_reg_read,
  input wire [6:0] i_reg_id,
  input wire [`ADCRRB_DATA_W-1:0] i_reg_wdata,
  input wire [CHANNELS-1:0] i_conv_done,
  input wire [`ADCRRB_RES_W-1:0] i_conv_result,
  input wire [`ADCRRB_SEL_W-1:0] i_conv_label,
  input wire i_esr_result_valid,
  output reg [`ADCRRB_DATA_W-1:0] o_reg_rdata,
  output reg o_reg_hit,
  output wire [CHANNELS*`ADCRRB_SEL_W-1:0] o_measurement_selector,
  output wire [CHANNELS-1:0] o_conv_request
);

  // ==========================================
  // Address decode
  wire [6:0] chan_id [0:3];
  assign chan_id[0] = `ADCRRB_ID_CHAN_A;
  assign chan_id[1] = `ADCRRB_ID_CHAN_B;
  assign chan_id[2] = `ADCRRB_ID_CHAN_C;
  assign chan_id[3] = `ADCRRB_ID_CHAN_D;

  wire state_reset;
  assign state_reset = i_wake_pin_state_reset | i_system_state_reset; // RQ4

  // SERIES_RESISTANCE_MEASURE labels are echoed only while SERIES_RESISTANCE_MEASURE results are present
  wire label_is_esr;
  assign label_is_esr = (i_conv_label >= `ADCRRB_SEL_ESR_VB) &&
                        (i_conv_label <= `ADCRRB_SEL_ESR_VC);
  wire label_valid;
  assign label_valid = label_is_esr & i_esr_result_valid; // RQ7

  wire [CHANNELS-1:0] hit;
  wire [CHANNELS*`ADCRRB_DATA_W-1:0] view;

  // ==========================================
  // Channels
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
      wire [`ADCRRB_SEL_W-1:0] echo;
      wire [`ADCRRB_RES_W-1:0] res;
      wire flag;
      assign hit[g] = (i_reg_id == chan_id[g % 4]);
      adcrrb_channel u_chan (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_state_reset(state_reset),
        .i_write(i_reg_write & hit[g]), // RQ1
        .i_read(i_reg_read & hit[g]), // RQ11
        .i_wdata(i_reg_wdata),
        .i_conv_done(i_conv_done[g]),
        .i_conv_result(i_conv_result),
        .i_conv_label(i_conv_label),
        .i_label_valid(label_valid),
        .o_measurement_selector(o_measurement_selector[g*`ADCRRB_SEL_W +: `ADCRRB_SEL_W]),
        .o_echo_selector(echo),
        .o_conversion_result(res),
        .o_conversion_done_flag(flag),
        .o_conv_request(o_conv_request[g])
      );
      assign view[g*`ADCRRB_DATA_W +: `ADCRRB_DATA_W] = {flag, 2'h0, echo, res}; // RQ2
    end
  endgenerate

  // ==========================================
  // Read data: sampled before the read clears the flag
  reg [`ADCRRB_DATA_W-1:0] next_rdata;
  reg next_hit;
  integer k;
  always @* begin
    next_rdata = {`ADCRRB_DATA_W{1'b0}};
    next_hit = 1'b0;
    for (k = 0; k < CHANNELS; k = k + 1) begin
      if (hit[k]) begin
        next_rdata = view[k*`ADCRRB_DATA_W +: `ADCRRB_DATA_W]; // RQ2
        next_hit = 1'b1;
      end
    end
  end

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= {`ADCRRB_DATA_W{1'b0}};
      o_reg_hit <= 1'b0;
    end else if (i_reg_read) begin
      o_reg_rdata <= next_rdata;
      o_reg_hit <= next_hit;
    end
  end

endmodule // adcrrb_bank

// [tb/adcrrb_props.sv]
// Purpose: port checks of the ADC bank
// Assumes: one clock domain
// Notes: bound below the module
`timescale 1ns/100ps
module adcrrb_props #(parameter CHANNELS = 4) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_wake_pin_state_reset,
  input wire i_system_state_reset,
  input wire i_reg_write,
  input wire i_reg_read,
  input wire [6:0] i_reg_id,
  input wire [19:0] i_reg_wdata,
  input wire [CHANNELS-1:0] i_conv_done,
  input wire [9:0] i_conv_result,
  input wire [19:0] o_reg_rdata,
  input wire o_reg_hit,
  input wire [CHANNELS*7-1:0] o_measurement_selector,
  input wire [CHANNELS-1:0] o_conv_request
);
  wire rs = i_wake_pin_state_reset | i_system_state_reset;
  wire [6:0] s0 = o_measurement_selector[6:0];
  wire [6:0] w7 = i_reg_wdata[6:0];
  wire in_map = i_reg_id inside {[7'h3A:7'h3D]};
  wire lst = s0 != 7'h00 && !(s0 inside {[7'h17:7'h1F], [7'h42:7'h45]}) && s0 < 7'h4E;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // ====
  // Channel A write, conversion end and reads; state reset, decode and bits 18:17 checks
  sequence s_done; i_conv_done[0] && o_conv_request[0] && !rs; endsequence
  sequence s_rd; i_reg_read && i_reg_id == 7'h3A && !i_conv_done[0] && !rs; endsequence
  a_write_sel: assert property (i_reg_write && i_reg_id == 7'h3A && !rs |=>
    s0 == $past(w7)) else $error("selector A not written");
  a_state_clear: assert property (rs |=>
    o_measurement_selector == '0 && o_conv_request == '0) else $error("state reset missed");
  a_unmapped_rd: assert property (i_reg_read && !in_map |=>
    !o_reg_hit && o_reg_rdata == 20'h00000) else $error("unmapped read answered");
  a_gap_zero: assert property (o_reg_hit |-> o_reg_rdata[18:17] == 2'h0)
    else $error("bits 18:17 not zero");
  a_hit_map: assert property (i_reg_read && in_map && !rs |=> o_reg_hit)
    else $error("channel read missed");
  a_flag_set: assert property (s_done ##1 s_rd |=>
    o_reg_rdata[19] && o_reg_rdata[9:0] == $past(i_conv_result, 2)) else $error("no new data");
  a_read_clear: assert property (s_rd ##1 s_rd |=> !o_reg_rdata[19])
    else $error("flag kept after read");
  a_req_map: assert property (o_conv_request[0] == lst)
    else $error("request for code wrong");
endmodule // adcrrb_props
bind adcrrb_bank adcrrb_props #(.CHANNELS(CHANNELS)) u_props (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_wake_pin_state_reset(i_wake_pin_state_reset),
  .i_system_state_reset(i_system_state_reset), .i_reg_write(i_reg_write),
  .i_reg_read(i_reg_read), .i_reg_id(i_reg_id), .i_reg_wdata(i_reg_wdata),
  .i_conv_done(i_conv_done), .i_conv_result(i_conv_result), .o_reg_rdata(o_reg_rdata),
  .o_reg_hit(o_reg_hit), .o_measurement_selector(o_measurement_selector),
  .o_conv_request(o_conv_request));

// [tb/adcrrb_conv_model.sv]
// Purpose: conversion engine stand-in
// Assumes: commanded by bench tasks
// Notes: result and label scrambled outside pulses
`timescale 1ns/100ps
module adcrrb_conv_model (
  input wire i_clock,
  output logic [3:0] o_done,
  output logic [9:0] o_result,
  output logic [6:0] o_label
);
  initial begin
    o_done = 4'h0;
    o_result = 10'h000;
    o_label = 7'h00;
  end
  // ====
  // Completion pulse, prompt or after n cycles
  task cv(input int g, input [9:0] r, input [6:0] l, input int n);
    repeat (n) @(negedge i_clock);
    o_done[g] = 1'b1;
    o_result = r;
    o_label = l;
    @(negedge i_clock);
    o_done = 4'h0;
    o_result = ~r;
    o_label = ~l;
  endtask
endmodule // adcrrb_conv_model

// [tb/adcrrb_bank_tb.sv]
// Purpose: bench of the ADC request/result bank
// Assumes: inputs change at falling edges
// Notes: expected reads queued, checked by monitor
`timescale 1ns/100ps
module adcrrb_bank_tb;
  logic i_clock = 0, i_sys_rst = 1, i_wake_pin_state_reset, i_system_state_reset;
  logic i_reg_write, i_reg_read, i_esr_result_valid = 0, o_reg_hit;
  logic [6:0] i_reg_id, c, sel [4], ech [4];
  logic [19:0] i_reg_wdata, o_reg_rdata;
  logic [3:0] o_conv_request, i_conv_done;
  logic [27:0] o_measurement_selector;
  logic [9:0] i_conv_result, res [4];
  logic [6:0] i_conv_label;
  logic flg [4];
  logic [20:0] q [$];
  int num_errors = 0, comparisons = 0, seed = 89374, i;
  logic [6:0] tbl [30] = '{7'h01, 7'h00, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08,
    7'h09, 7'h0A, 7'h0B, 7'h13, 7'h14, 7'h17, 7'h1F, 7'h20, 7'h2B, 7'h2C, 7'h31, 7'h32,
    7'h35, 7'h36, 7'h41, 7'h42, 7'h45, 7'h46, 7'h4D, 7'h4E, 7'h7F};
  adcrrb_bank DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_wake_pin_state_reset(i_wake_pin_state_reset), .i_system_state_reset(i_system_state_reset),
    .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .i_reg_id(i_reg_id),
    .i_reg_wdata(i_reg_wdata), .i_conv_done(i_conv_done), .i_conv_result(i_conv_result),
    .i_conv_label(i_conv_label), .i_esr_result_valid(i_esr_result_valid),
    .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
    .o_measurement_selector(o_measurement_selector), .o_conv_request(o_conv_request));
  adcrrb_conv_model m (.i_clock(i_clock), .o_done(i_conv_done), .o_result(i_conv_result),
    .o_label(i_conv_label));
  always #25 i_clock = ~i_clock;
  // ====
  // Checking and driving
  function logic lst(input [6:0] s);
    return s != 0 && !(s inside {[7'h17:7'h1F], [7'h42:7'h45]}) && s < 7'h4E;
  endfunction
  task chk(input [20:0] s, e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task op(input w, r, input [6:0] id, input [19:0] d, input [1:0] k = 0);
    logic [1:0] g;
    logic hit;
    g = id[1:0] - 2'd2;
    hit = id inside {[7'h3A:7'h3D]};
    {i_reg_write, i_reg_read, i_reg_id, i_reg_wdata} = {w, r, id, d};
    {i_system_state_reset, i_wake_pin_state_reset} = k;
    if (k != 0) for (int j = 0; j < 4; j++) {sel[j], ech[j], res[j], flg[j]} = 0;
    if (w && hit) {sel[g], ech[g]} = {d[6:0], d[6:0]};
    if (r) q.push_back(hit ? {1'b1, flg[g], 2'b00, ech[g], res[g]} : 21'h0);
    if (r && hit) flg[g] = 0;
    @(negedge i_clock);
  endtask
  task conv(input int g, input [9:0] r, input [6:0] l, input int n);
    if (lst(sel[g])) {flg[g], res[g]} = {1'b1, r};
    if (i_esr_result_valid && l inside {[7'h14:7'h16]}) ech[g] = l;
    fork
      m.cv(g, r, l, n);
      repeat (n + 1) op(0, 0, 0, 0);
    join
  endtask
  task print_verdict;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge i_clock) if (i_reg_read && !i_sys_rst) begin
    @(negedge i_clock);
    chk({o_reg_hit, o_reg_rdata}, q.pop_front());
  end
  initial begin
    #2000000;
    num_errors++;
    print_verdict;
  end
  initial begin
    repeat (20) op(0, 0, 0, 0, 3);
    i_sys_rst = 0;
    for (i = 0; i < 4; i++) op(0, 1, 7'h3A + i, 0);
    for (i = 0; i < 40; i++) begin
      c = i < 30 ? tbl[i] : 7'($random(seed));
      op(1, 0, 7'h3A + i % 4, {13'($random(seed)), c});
      chk(o_conv_request[i % 4], lst(c));
      chk(o_measurement_selector[7 * (i % 4) +: 7], c);
      conv(i % 4, 10'($random(seed)), c, i % 3);
      op(0, 1, 7'h3A + i % 4, 0);
      op(0, 1, 7'h3A + i % 4, 0);
    end
    i_esr_result_valid = 1;
    op(1, 0, 7'h3D, 20'h00014);
    conv(3, 10'h2A5, 7'h15, 1);
    op(0, 1, 7'h3D, 0);
    op(1, 0, 7'h3E, 20'h0007F);
    op(0, 1, 7'h3E, 0);
    op(0, 1, 7'h39, 0);
    for (i = 1; i < 3; i++) begin
      op(1, 0, 7'h3B, 20'h00009);
      conv(1, 10'h3FF, 7'h09, 0);
      op(0, 0, 0, 0, i);
      op(0, 1, 7'h3B, 0);
    end
    repeat (2) op(0, 0, 0, 0);
    print_verdict;
  end
endmodule // adcrrb_bank_tb
